// File: rtl/display_status_readback.sv
/*
  Status read-back responder. The command side runs on the link clock,
  the status snapshot on the system clock; a toggle handshake carries
  the command code over and another carries the reply word back.
  Assumes the host keeps the link clock running from a command until
  the last reply byte has been taken, and that status flags come from
  logic on clk_sys_in while the three sync lines come straight off pins.
*/
`timescale 1ns/10ps

// Function
// R1: status read 09h returns four bytes, bits 31:24 first down to 7:0.
// R2: bit 31 is one while the voltage booster runs.
// R3: bits 30:23 mirror memory access control bits 7:0.
// R4: bits 22:20 carry the pixel format code 101, 110 or 111.
// R5: bits 19..16 show idle, partial, sleep-out and normal mode.
// R6: bit 15 shows vertical scrolling; bit 14 always reads zero.
// R7: bits 13..10 show inversion, all on, all off and display on.
// R8: bit 9 shows tearing output enable; bit 5 its blanking mode.
// R9: bits 8:6 carry the selected gamma curve code.
// R10: bits 4:2 give sync and pixel clock line levels at command receipt.
// R11: bit 1 reads zero; bit 0 flags a detected link parity error.
// R12: power mode read 0Ah returns booster..display-on in bits 7:2, zeros below.
// R13: access control read 0Bh returns the memory access control setting.
// R14: pixel format read 0Ch returns 111 in bits 6:4, 000 in 2:0.
// R15: host ignores the format group of the unused interface type; the bench compares the whole 0Ch reply byte with 70h.
// R16: all status bits are captured once per command as one snapshot.
module display_status_readback (
  // system clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic soft_reset_in,
  // live display state, system clock domain
  input wire logic booster_on_in,
  input wire logic [7:0] memory_access_control_in,
  input wire logic [2:0] pixel_format_setting_in,
  input wire logic idle_on_in,
  input wire logic partial_on_in,
  input wire logic sleep_out_in,
  input wire logic normal_on_in,
  input wire logic vscroll_on_in,
  input wire logic inversion_on_in,
  input wire logic all_pixels_on_in,
  input wire logic all_pixels_off_in,
  input wire logic display_on_in,
  input wire logic tear_enable_in,
  input wire logic tear_mode_in,
  input wire logic [2:0] gamma_select_in,
  input wire logic parity_error_in,
  // video stream line pins, asynchronous
  input wire logic hsync_pin_in,
  input wire logic vsync_pin_in,
  input wire logic pixel_clock_line_in,
  // command link, link clock domain
  input wire logic clk_link_in,
  input wire logic cmd_strobe_in,
  input wire logic [7:0] cmd_code_in,
  output logic cmd_busy_out,
  output logic [7:0] resp_byte_out,
  output logic resp_valid_out,
  input wire logic resp_take_in
);

  // ==========================================================
  // state types, one struct per clock domain
  typedef struct packed {
    logic [2:0] cmd_sync;
    logic cmd_level;
    logic [2:0][2:0] line_sync;
    logic [2:0] line_level;
    logic [31:0] reply_word;
    logic [2:0] reply_len;
    logic reply_tgl;
  } sys_state_t;

  typedef struct packed {
    logic cmd_tgl;
    logic [7:0] cmd_code;
    logic busy;
    logic [2:0] ack_sync;
    logic ack_level;
    logic [31:0] shift;
    logic [2:0] left;
    logic valid;
  } link_state_t;

  sys_state_t sys_q;
  sys_state_t next_sys;
  link_state_t link_q;
  link_state_t next_link;
  logic cmd_event;
  logic ack_event;
  logic [2:0] pin_lines;

  // ==========================================================
  // system domain: synchronisers and snapshot
  assign pin_lines = {hsync_pin_in, vsync_pin_in, pixel_clock_line_in};
  // a change counts only once the second and third stages agree
  assign cmd_event = (sys_q.cmd_sync[1] == sys_q.cmd_sync[2]) &&
                     (sys_q.cmd_sync[2] != sys_q.cmd_level);

  always_comb begin
    next_sys = sys_q;
    next_sys.cmd_sync = {sys_q.cmd_sync[1:0], link_q.cmd_tgl};
    if (sys_q.cmd_sync[1] == sys_q.cmd_sync[2]) begin
      next_sys.cmd_level = sys_q.cmd_sync[2];
    end
    for (int i = 0; i < 3; i++) begin
      next_sys.line_sync[i] = {sys_q.line_sync[i][1:0], pin_lines[i]};
      if (sys_q.line_sync[i][1] == sys_q.line_sync[i][2]) begin
        next_sys.line_level[i] = sys_q.line_sync[i][2];
      end
    end
    if (soft_reset_in) begin
      next_sys.reply_word = readback_pkg::REPLY_RESET;
    end
    // cmd_code is held still by the link side until the reply returns
    if (cmd_event) begin
      next_sys.reply_tgl = ~sys_q.reply_tgl;
      next_sys.reply_word = readback_pkg::REPLY_RESET;
      next_sys.reply_len = readback_pkg::SINGLE_LEN;
      case (link_q.cmd_code)
        readback_pkg::READ_STATUS_WORD_CMD: begin
          next_sys.reply_len = readback_pkg::STATUS_LEN;
          // R2 booster status
          next_sys.reply_word[readback_pkg::STAT_BOOST] = booster_on_in;
          // R3 access control mirror
          next_sys.reply_word[readback_pkg::STAT_MAC_HI:readback_pkg::STAT_MAC_LO] =
            memory_access_control_in;
          // R4 pixel format code
          next_sys.reply_word[readback_pkg::STAT_FMT_HI:readback_pkg::STAT_FMT_LO] =
            pixel_format_setting_in;
          // R5 mode flags
          next_sys.reply_word[readback_pkg::STAT_IDLE] = idle_on_in;
          next_sys.reply_word[readback_pkg::STAT_PARTIAL] = partial_on_in;
          next_sys.reply_word[readback_pkg::STAT_SLEEP_OUT] = sleep_out_in;
          next_sys.reply_word[readback_pkg::STAT_NORMAL] = normal_on_in;
          // R6 scrolling, horizontal never supported
          next_sys.reply_word[readback_pkg::STAT_VSCROLL] = vscroll_on_in;
          next_sys.reply_word[readback_pkg::STAT_HSCROLL] = 1'b0;
          // R7 display flags
          next_sys.reply_word[readback_pkg::STAT_INVERT] = inversion_on_in;
          next_sys.reply_word[readback_pkg::STAT_ALL_ON] = all_pixels_on_in;
          next_sys.reply_word[readback_pkg::STAT_ALL_OFF] = all_pixels_off_in;
          next_sys.reply_word[readback_pkg::STAT_DISP_ON] = display_on_in;
          // R8 tearing output
          next_sys.reply_word[readback_pkg::STAT_TEAR_ON] = tear_enable_in;
          next_sys.reply_word[readback_pkg::STAT_TEAR_MODE] = tear_mode_in;
          // R9 gamma curve
          next_sys.reply_word[readback_pkg::STAT_GAMMA_HI:readback_pkg::STAT_GAMMA_LO] =
            gamma_select_in;
          // R10 line levels at receipt
          next_sys.reply_word[readback_pkg::STAT_HSYNC] = sys_q.line_level[2];
          next_sys.reply_word[readback_pkg::STAT_VSYNC] = sys_q.line_level[1];
          next_sys.reply_word[readback_pkg::STAT_PCLK] = sys_q.line_level[0];
          // R11 reserved and parity
          next_sys.reply_word[readback_pkg::STAT_RSVD] = 1'b0;
          next_sys.reply_word[readback_pkg::STAT_PARITY] = parity_error_in;
        end
        // R12 power mode byte
        readback_pkg::READ_POWER_MODE_CMD: begin
          next_sys.reply_word[31:24] = {booster_on_in, idle_on_in, partial_on_in,
                                        sleep_out_in, normal_on_in, display_on_in,
                                        2'h0};
        end
        // R13 access control byte
        readback_pkg::READ_ACCESS_CONTROL_CMD: begin
          next_sys.reply_word[31:24] = memory_access_control_in;
        end
        // R14 fixed format byte
        readback_pkg::READ_PIXEL_FORMAT_CMD: begin
          next_sys.reply_word[31:24] = {1'b0, readback_pkg::VIDEO_STREAM_FMT,
                                        1'b0, readback_pkg::COMMAND_PATH_FMT};
        end
        default: begin
          next_sys.reply_len = readback_pkg::NO_LEN;
        end
      endcase
    end
  end

  // R16 one snapshot per command
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sys_q <= '0;
    end else begin
      sys_q <= next_sys;
    end
  end

  // ==========================================================
  // link domain: command intake and byte return
  assign ack_event = (link_q.ack_sync[1] == link_q.ack_sync[2]) &&
                     (link_q.ack_sync[2] != link_q.ack_level);

  always_comb begin
    next_link = link_q;
    next_link.ack_sync = {link_q.ack_sync[1:0], sys_q.reply_tgl};
    if (link_q.ack_sync[1] == link_q.ack_sync[2]) begin
      next_link.ack_level = link_q.ack_sync[2];
    end
    // only the four read-back codes are taken; others are left to other blocks
    if (cmd_strobe_in && !link_q.busy &&
        cmd_code_in >= readback_pkg::READ_STATUS_WORD_CMD &&
        cmd_code_in <= readback_pkg::READ_PIXEL_FORMAT_CMD) begin
      next_link.cmd_code = cmd_code_in;
      next_link.cmd_tgl = ~link_q.cmd_tgl;
      next_link.busy = 1'b1;
    end
    if (ack_event) begin
      next_link.shift = sys_q.reply_word;
      next_link.left = sys_q.reply_len;
      next_link.valid = 1'b1;
    end
    // R1 bytes leave high first
    if (link_q.valid && resp_take_in) begin
      if (link_q.left == readback_pkg::SINGLE_LEN) begin
        next_link.valid = 1'b0;
        next_link.busy = 1'b0;
        next_link.left = readback_pkg::NO_LEN;
      end else begin
        next_link.shift = {link_q.shift[23:0], 8'h00};
        next_link.left = link_q.left - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_link_in or posedge rst_in) begin
    if (rst_in) begin
      link_q <= '0;
    end else begin
      link_q <= next_link;
    end
  end

  assign cmd_busy_out = link_q.busy;
  assign resp_valid_out = link_q.valid;
  assign resp_byte_out = link_q.shift[31:24];

  // ==========================================================
  // checks
  AST_BYTE_ORDER: assert property ( // R1
    @(posedge clk_link_in) disable iff (rst_in)
    (link_q.valid && resp_take_in && link_q.left > 3'h1)
      |=> (resp_valid_out && resp_byte_out == $past(link_q.shift[23:16])))
    else $error("reply byte order broken");

  AST_BOOSTER: assert property ( // R2
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> (sys_q.reply_word[31] == $past(booster_on_in) &&
           sys_q.reply_len == readback_pkg::STATUS_LEN))
    else $error("booster bit or status length wrong");

  AST_MAC_MIRROR: assert property ( // R3
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> sys_q.reply_word[30:23] == $past(memory_access_control_in))
    else $error("access control mirror wrong");

  AST_FMT_MODES: assert property ( // R4
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> sys_q.reply_word[22:16] == $past({pixel_format_setting_in, idle_on_in,
                                            partial_on_in, sleep_out_in, normal_on_in}))
    else $error("format or mode bits wrong");

  AST_FIXED_ZERO: assert property ( // R6
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> (!sys_q.reply_word[14] && !sys_q.reply_word[1] &&
           sys_q.reply_word[0] == $past(parity_error_in)))
    else $error("fixed status bits wrong");

  AST_LINE_LEVELS: assert property ( // R10
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> sys_q.reply_word[4:2] == $past(sys_q.line_level))
    else $error("line levels not captured at receipt");

  AST_POWER_BYTE: assert property ( // R12
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_POWER_MODE_CMD)
      |=> (sys_q.reply_word[25:24] == 2'h0 && sys_q.reply_word[31] == $past(booster_on_in)
           && sys_q.reply_len == readback_pkg::SINGLE_LEN))
    else $error("power mode byte wrong");

  AST_MAC_BYTE: assert property ( // R13
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_ACCESS_CONTROL_CMD)
      |=> sys_q.reply_word[31:24] == $past(memory_access_control_in))
    else $error("access control byte wrong");

  AST_FORMAT_BYTE: assert property ( // R14
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_PIXEL_FORMAT_CMD)
      |=> sys_q.reply_word[31:24] == 8'h70)
    else $error("pixel format byte wrong");

  AST_SNAPSHOT: assert property ( // R16
    @(posedge clk_sys_in) disable iff (rst_in)
    (!cmd_event && !soft_reset_in) |=> $stable(sys_q.reply_word))
    else $error("snapshot changed without a command");

  AST_SOFT_CLEAR: assert property ( // R16
    @(posedge clk_sys_in) disable iff (rst_in)
    (soft_reset_in && !cmd_event) |=> sys_q.reply_word == readback_pkg::REPLY_RESET)
    else $error("held reply not cleared by software reset");

  AST_MODE_FLAGS: assert property ( // R5
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> sys_q.reply_word[19:16] == $past({idle_on_in, partial_on_in, sleep_out_in,
                                            normal_on_in}))
    else $error("mode flag bits wrong");

  AST_VSCROLL: assert property ( // R6
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> sys_q.reply_word[15] == $past(vscroll_on_in))
    else $error("vertical scroll bit wrong");

  AST_DISPLAY_FLAGS: assert property ( // R7
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> sys_q.reply_word[13:10] == $past({inversion_on_in, all_pixels_on_in,
                                            all_pixels_off_in, display_on_in}))
    else $error("display flag bits wrong");

  AST_TEAR_BITS: assert property ( // R8
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> {sys_q.reply_word[9], sys_q.reply_word[5]} == $past({tear_enable_in, tear_mode_in}))
    else $error("tearing bits wrong");

  AST_GAMMA: assert property ( // R9
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> sys_q.reply_word[8:6] == $past(gamma_select_in))
    else $error("gamma curve code wrong");

  AST_PARITY_BIT: assert property ( // R11
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_STATUS_WORD_CMD)
      |=> sys_q.reply_word[1:0] == {1'b0, $past(parity_error_in)})
    else $error("reserved or parity bit wrong");

  AST_POWER_FLAGS: assert property ( // R12
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_event && link_q.cmd_code == readback_pkg::READ_POWER_MODE_CMD)
      |=> sys_q.reply_word[30:26] == $past({idle_on_in, partial_on_in, sleep_out_in,
                                            normal_on_in, display_on_in}))
    else $error("power mode flags wrong");

  AST_BYTE_HOLD: assert property ( // R1
    @(posedge clk_link_in) disable iff (rst_in)
    (resp_valid_out && !resp_take_in) |=> (resp_valid_out && $stable(resp_byte_out)))
    else $error("reply byte dropped before it was taken");

  AST_LAST_BYTE: assert property ( // R1
    @(posedge clk_link_in) disable iff (rst_in)
    (link_q.valid && resp_take_in && link_q.left == readback_pkg::SINGLE_LEN)
      |=> (!resp_valid_out && !cmd_busy_out))
    else $error("reply not closed after its last byte");

endmodule : display_status_readback

// File: common/readback_pkg.sv
/*
  Constants for the display status read-back responder: command codes,
  status field positions, fixed read-back values and reply lengths.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package readback_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] READ_STATUS_WORD_CMD = 8'h09;
  localparam logic [7:0] READ_POWER_MODE_CMD = 8'h0a;
  localparam logic [7:0] READ_ACCESS_CONTROL_CMD = 8'h0b;
  localparam logic [7:0] READ_PIXEL_FORMAT_CMD = 8'h0c;

  // ==========================================================
  // status word field positions
  localparam int STAT_BOOST = 31;
  localparam int STAT_MAC_HI = 30;
  localparam int STAT_MAC_LO = 23;
  localparam int STAT_FMT_HI = 22;
  localparam int STAT_FMT_LO = 20;
  localparam int STAT_IDLE = 19;
  localparam int STAT_PARTIAL = 18;
  localparam int STAT_SLEEP_OUT = 17;
  localparam int STAT_NORMAL = 16;
  localparam int STAT_VSCROLL = 15;
  localparam int STAT_HSCROLL = 14;
  localparam int STAT_INVERT = 13;
  localparam int STAT_ALL_ON = 12;
  localparam int STAT_ALL_OFF = 11;
  localparam int STAT_DISP_ON = 10;
  localparam int STAT_TEAR_ON = 9;
  localparam int STAT_GAMMA_HI = 8;
  localparam int STAT_GAMMA_LO = 6;
  localparam int STAT_TEAR_MODE = 5;
  localparam int STAT_HSYNC = 4;
  localparam int STAT_VSYNC = 3;
  localparam int STAT_PCLK = 2;
  localparam int STAT_RSVD = 1;
  localparam int STAT_PARITY = 0;

  // ==========================================================
  // fixed values and reset values
  localparam logic [2:0] VIDEO_STREAM_FMT = 3'h7;
  localparam logic [2:0] COMMAND_PATH_FMT = 3'h0;
  localparam logic [31:0] REPLY_RESET = 32'h0;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [2:0] STATUS_LEN = 3'h4;
  localparam logic [2:0] SINGLE_LEN = 3'h1;
  localparam logic [2:0] NO_LEN = 3'h0;

endpackage : readback_pkg

// File: testbench/host_link_model.sv
/*
  Host side of the command link: makes the link clock, sends one command
  code and takes the reply bytes one by one.
  Assumes the responder raises resp_valid_in within 60 link cycles.
*/
`timescale 1ns/10ps

module host_link_model (
  // reset and link clock
  input wire logic rst_in,
  output logic clk_link_out,
  // command out
  output logic cmd_strobe_out,
  output logic [7:0] cmd_code_out,
  // reply in
  input wire logic cmd_busy_in,
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_byte_in,
  output logic resp_take_out
);
  logic active;

  initial begin
    active = 1'b0;
    cmd_strobe_out = 1'b0;
    cmd_code_out = 8'h00;
    resp_take_out = 1'b0;
  end

  // ==========================================================
  // link clock: runs in reset and within a transfer, else stands low
  initial begin
    clk_link_out = 1'b0;
    #3;
    forever begin
      #16;
      if (rst_in || active || clk_link_out) begin
        clk_link_out = ~clk_link_out;
      end
    end
  end

  // ==========================================================
  // one command; n = 0 reports in bit 0 whether busy or any reply showed up
  task automatic transfer(input logic [7:0] code, input int n, output logic [31:0] word);
    int k;
    word = 32'h0;
    active = 1'b1;
    repeat (2) @(posedge clk_link_out);
    cmd_strobe_out <= 1'b1;
    cmd_code_out <= code;
    @(posedge clk_link_out);
    cmd_strobe_out <= 1'b0;
    // code lines carry nothing now; show the inverse so stale use is seen
    cmd_code_out <= ~code;
    if (n == 0) begin
      repeat (30) begin
        @(posedge clk_link_out);
        word[0] = word[0] | resp_valid_in | cmd_busy_in;
      end
    end
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge clk_link_out);
        k++;
      end while (resp_valid_in !== 1'b1 && k < 60);
      // raw byte handed up; the caller judges the unused format group
      word = {word[23:0], (resp_valid_in === 1'b1) ? resp_byte_in : 8'hxx};
      resp_take_out <= 1'b1;
      @(posedge clk_link_out);
      resp_take_out <= 1'b0;
    end
    repeat (2) @(posedge clk_link_out);
    active = 1'b0;
  endtask : transfer
endmodule : host_link_model

// File: testbench/display_status_readback_tb.sv
/*
  Self-checking bench for the status read-back responder: sets display
  state, reads it back through the host model and compares.
  Assumes readback_pkg and the host link model are compiled first.
*/
`timescale 1ns/10ps

module display_status_readback_tb;
  logic clk_sys_in, rst_in, soft_reset_in;
  logic clk_link, strobe, take, busy, valid;
  logic [7:0] code, rbyte;
  logic [31:0] st, got;
  int err_count, comparisons, cyc;
  logic [31:0] pats [6] = '{32'hffff_ffff, 32'h0000_0000, 32'h12d5_2a5d,
                            32'hbee3_c4a8, 32'h6df9_0cc3, 32'h0fa0_0050};
  logic [7:0] bad [3] = '{8'h0d, 8'h08, 8'hff};

  display_status_readback u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in),
    .booster_on_in(st[31]), .memory_access_control_in(st[30:23]),
    .pixel_format_setting_in(st[22:20]), .idle_on_in(st[19]), .partial_on_in(st[18]),
    .sleep_out_in(st[17]), .normal_on_in(st[16]), .vscroll_on_in(st[15]),
    .inversion_on_in(st[13]), .all_pixels_on_in(st[12]), .all_pixels_off_in(st[11]),
    .display_on_in(st[10]), .tear_enable_in(st[9]), .gamma_select_in(st[8:6]),
    .tear_mode_in(st[5]), .hsync_pin_in(st[4]), .vsync_pin_in(st[3]),
    .pixel_clock_line_in(st[2]), .parity_error_in(st[0]),
    .clk_link_in(clk_link), .cmd_strobe_in(strobe), .cmd_code_in(code),
    .cmd_busy_out(busy), .resp_byte_out(rbyte), .resp_valid_out(valid),
    .resp_take_in(take)
  );

  host_link_model u_host (
    .rst_in(rst_in), .clk_link_out(clk_link), .cmd_strobe_out(strobe),
    .cmd_code_out(code), .cmd_busy_in(busy), .resp_valid_in(valid),
    .resp_byte_in(rbyte), .resp_take_out(take)
  );

  // ==========================================================
  // clock and timeout
  initial begin
    clk_sys_in = 1'b0;
    forever begin
      #12.5 clk_sys_in = ~clk_sys_in;
    end
  end

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // state is applied well ahead so the pin synchronisers have settled
  task automatic settle(input logic [31:0] v);
    @(posedge clk_sys_in);
    st <= v;
    repeat (10) @(posedge clk_sys_in);
  endtask : settle

  // ==========================================================
  // main sequence
  initial begin
    rst_in = 1'b1;
    soft_reset_in = 1'b0;
    st = 32'h0;
    err_count = 0;
    comparisons = 0;
    cyc = 0;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk({22'h0, busy, valid, rbyte}, 32'h0);
    foreach (pats[i]) begin
      settle(pats[i]);
      fork
        u_host.transfer(readback_pkg::READ_STATUS_WORD_CMD, 4, got);
        begin
          // state flips once the reply exists; the snapshot must not follow
          wait (valid === 1'b1);
          @(posedge clk_sys_in);
          st <= ~pats[i];
        end
      join
      chk(got, pats[i] & 32'hffff_bffd);
      chk({31'h0, busy}, 32'h0);
      settle(pats[i]);
      u_host.transfer(readback_pkg::READ_POWER_MODE_CMD, 1, got);
      chk(got, {24'h0, pats[i][31], pats[i][19:16], pats[i][10], 2'b00});
      u_host.transfer(readback_pkg::READ_ACCESS_CONTROL_CMD, 1, got);
      chk(got, {24'h0, pats[i][30:23]});
      u_host.transfer(readback_pkg::READ_PIXEL_FORMAT_CMD, 1, got);
      chk(got, 32'h0000_0070);
    end
    foreach (bad[i]) begin
      u_host.transfer(bad[i], 0, got);
      chk(got, 32'h0);
    end
    @(posedge clk_sys_in);
    soft_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    soft_reset_in <= 1'b0;
    u_host.transfer(readback_pkg::READ_ACCESS_CONTROL_CMD, 1, got);
    chk(got, {24'h0, pats[5][30:23]});
    end_sim();
  end
endmodule : display_status_readback_tb
